// ===== bench/cgrf_exec_model.sv
// partner model: execute stage issuing timed arithmetic on registers one and two
`timescale 1ns/100ps
`default_nettype none
module cgrf_exec_model (
  input wire logic sys_clk,
  input wire logic op_done,
  output logic op_start,
  output logic [3:0] op_code,
  output logic [2:0] op_dst_index,
  output logic [2:0] op_src_index,
  output logic [1:0] op_dst_width,
  output logic op_dst_ext,
  output logic op_dst_high
);
  initial begin
    {op_start, op_code, op_dst_index, op_src_index, op_dst_width, op_dst_ext, op_dst_high} = '0;
  end
  // operands are read at write time, so the fields stand until the next issue
  task automatic issue(input logic [3:0] code, input logic [1:0] w, output int lat);
    @(posedge sys_clk);
    op_start <= 1'b1;
    op_code <= code;
    op_dst_index <= 3'h1;
    op_src_index <= 3'h2;
    op_dst_width <= w;
    @(posedge sys_clk);
    op_start <= 1'b0;
    lat = 0;
    // count edges after the start edge until the done pulse is sampled
    do begin
      @(posedge sys_clk);
      lat++;
    end while (op_done !== 1'b1 && lat < 40);
  endtask
endmodule // cgrf_exec_model
`default_nettype wire

// ===== bench/cgrf_top_chk.sv
// checker: timing and value relations at the register file ports
`timescale 1ns/100ps
`default_nettype none
module cgrf_top_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic op_start,
  input wire logic [3:0] op_code,
  input wire logic [1:0] sp_cmd,
  input wire logic [1:0] pc_cmd,
  input wire logic [23:0] pc_load_value,
  input wire logic [15:0] reset_vector_data,
  input wire logic wr_en,
  input wire logic ccr_wr_en,
  input wire logic [7:0] ccr_wr_data,
  input wire logic ccr_imask_set,
  input wire logic [1:0] rd_a_width,
  input wire logic [31:0] rd_a_data,
  input wire logic [15:0] rd_a_addr,
  input wire logic [23:0] stack_pointer,
  input wire logic [23:0] program_counter,
  input wire logic [15:0] fetch_addr,
  input wire logic [7:0] condition_code_reg,
  input wire logic op_busy,
  input wire logic op_done
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic rst_d;
  logic go;
  ////////////////////////////////////////////////////////////////////////////////
  // delayed reset marks the vector load edge, where ops and pc commands are ignored
  always_ff @(posedge sys_clk) begin
    rst_d <= rst;
  end
  assign go = op_start && !op_busy && !op_done && !rst_d;
  ////////////////////////////////////////////////////////////////////////////////
  property p_ccr_rst; rst_d |-> condition_code_reg[7]; endproperty
  a_ccr_rst: assert property (p_ccr_rst) else $error("mask bit not set by reset");
  property p_vec; rst_d |=> program_counter == {8'h00, $past(reset_vector_data)}; endproperty
  a_vec: assert property (p_vec) else $error("pc not loaded from vector");
  property p_fetch; fetch_addr == {program_counter[15:1], 1'b0}; endproperty
  a_fetch: assert property (p_fetch) else $error("fetch address lsb not zero");
  property p_step;
    pc_cmd == cgrf_pkg::CGRF_PC_STEP && !rst_d |=>
      program_counter == $past(program_counter) + 24'h000002;
  endproperty
  a_step: assert property (p_step) else $error("pc step wrong");
  property p_load;
    pc_cmd == cgrf_pkg::CGRF_PC_LOAD && !rst_d |=> program_counter == $past(pc_load_value);
  endproperty
  a_load: assert property (p_load) else $error("pc load wrong");
  property p_add; go && op_code < 4'h6 |-> ##1 (op_busy && !op_done) ##1 op_done; endproperty
  a_add: assert property (p_add) else $error("add or sub not done in 2");
  property p_short;
    go && (op_code == 4'h6 || op_code == 4'h7) |->
      ##1 !op_done [*8] ##1 !op_done [*5] ##1 op_done;
  endproperty
  a_short: assert property (p_short) else $error("short mul or div not done in 14");
  property p_long;
    go && (op_code == 4'h8 || op_code == 4'h9) |->
      ##1 !op_done [*8] ##1 !op_done [*8] ##1 !op_done [*5] ##1 op_done;
  endproperty
  a_long: assert property (p_long) else $error("long mul or div not done in 22");
  property p_ccr_wr;
    ccr_wr_en && !ccr_imask_set |=> condition_code_reg == $past(ccr_wr_data);
  endproperty
  a_ccr_wr: assert property (p_ccr_wr) else $error("ccr write lost");
  property p_sp;
    sp_cmd == cgrf_pkg::CGRF_SP_PUSH_WORD && !wr_en && !op_busy |=>
      stack_pointer == $past(stack_pointer) - 24'h000002;
  endproperty
  a_sp: assert property (p_sp) else $error("stack push wrong");
  property p_rd; rd_a_width == 2'h2 |=> rd_a_data[15:0] == rd_a_addr; endproperty
  a_rd: assert property (p_rd) else $error("address and data views differ");
  // main scenarios reached
  c_add: cover property (go && op_code == 4'h1);
  c_long: cover property (go && op_code == 4'h9);
  c_push: cover property (sp_cmd == cgrf_pkg::CGRF_SP_PUSH_WORD);
endmodule // cgrf_top_chk
bind cgrf_top cgrf_top_chk i_cgrf_top_chk (.*);
`default_nettype wire

// ===== bench/cgrf_top_tb.sv
// testbench: register file lanes, timed ops, pc, stack and condition codes
`timescale 1ns/100ps
`default_nettype none
module cgrf_top_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] rd_a_index = 3'h0, rd_b_index = 3'h0, wr_index = 3'h0;
  logic [1:0] rd_a_width = 2'h2, rd_b_width = 2'h2, wr_width = 2'h2, sp_cmd = 2'h0;
  logic rd_a_ext = 1'b0, rd_a_high = 1'b0, rd_b_ext = 1'b0, rd_b_high = 1'b0;
  logic wr_en = 1'b0, wr_ext = 1'b0, wr_high = 1'b0, ccr_wr_en = 1'b0, ccr_imask_set = 1'b0;
  logic [31:0] wr_data = 32'h0;
  logic [1:0] pc_cmd = 2'h0;
  logic [23:0] pc_load_value = 24'h0;
  logic [15:0] reset_vector_data = 16'h1235;
  logic [7:0] ccr_wr_data = 8'h0;
  logic op_start, op_dst_ext, op_dst_high, reset_sequence, op_busy, op_done;
  logic [3:0] op_code;
  logic [2:0] op_dst_index, op_src_index;
  logic [1:0] op_dst_width;
  logic [31:0] rd_a_data, rd_b_data, v;
  logic [15:0] rd_a_addr, fetch_addr;
  logic [23:0] stack_pointer, program_counter;
  logic [7:0] condition_code_reg;
  int n_mismatch = 0;
  int cmp_count = 0;
  int lat;
  logic [31:0] ex [10] = '{32'h12345610, 32'h12345810, 32'h12355810,
                          32'h123456d0, 32'h123455d0, 32'h123355d0,
                          32'h12345600, 32'h123410b7, 32'h0061ce00, 32'h12345607};
  always #5 sys_clk = ~sys_clk;
  cgrf_top i_cgrf_top (.*);
  cgrf_exec_model i_cgrf_exec_model (.*);
  ////////////////////////////////////////////////////////////////////////////////
  // shared compare and port tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] i, input logic [1:0] w, input logic e, h,
                    input logic [31:0] d);
    @(posedge sys_clk);
    {wr_en, wr_index, wr_width, wr_ext, wr_high, wr_data} <= {1'b1, i, w, e, h, d};
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask
  // read data lands on the same edge that samples the index; odd ones via port b
  task automatic rd(input logic [2:0] i, input logic [1:0] w, input logic e, h,
                    output logic [31:0] d);
    @(posedge sys_clk);
    {rd_a_index, rd_a_width, rd_a_ext, rd_a_high} <= {i, w, e, h};
    {rd_b_index, rd_b_width, rd_b_ext, rd_b_high} <= {i, w, e, h};
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    d = i[0] ? rd_b_data : rd_a_data;
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk(32'(program_counter), 32'h00001235, "vector load");
    chk(32'(fetch_addr), 32'h00001234, "fetch lsb");
    chk(32'(reset_sequence), 32'h1, "seq flag");
    chk(32'(condition_code_reg[7]), 32'h1, "mask bit");
    $display("t_reset done");
  endtask
  task automatic t_gen;
    for (int i = 0; i < 8; i++) wr(3'(i), 2'h2, 1'b0, 1'b0, 32'h01010101 * 32'(i + 1));
    for (int i = 0; i < 8; i++) begin
      rd(3'(i), 2'h2, 1'b0, 1'b0, v);
      chk(v, 32'h01010101 * 32'(i + 1), "word");
    end
    // partial writes into register three must leave the other lanes alone
    wr(3'h3, 2'h1, 1'b1, 1'b0, 32'h0000beef);
    wr(3'h3, 2'h0, 1'b0, 1'b1, 32'h0000005a);
    wr(3'h3, 2'h0, 1'b0, 1'b0, 32'h000000c3);
    rd(3'h3, 2'h2, 1'b0, 1'b0, v);
    chk(v, 32'hbeef5ac3, "merge");
    rd(3'h3, 2'h1, 1'b1, 1'b0, v);
    chk(v, 32'h0000beef, "extended half");
    rd(3'h3, 2'h0, 1'b0, 1'b1, v);
    chk(v, 32'h0000005a, "high byte");
    rd(3'h3, 2'h1, 1'b0, 1'b0, v);
    chk(v, 32'h00005ac3, "basic half");
    chk(32'(rd_a_addr), 32'h00005ac3, "address view");
    rd(3'h5, 2'h2, 1'b0, 1'b0, v);
    chk(v, 32'h06060606, "neighbour kept");
    $display("t_gen done");
  endtask
  task automatic t_ops;
    for (int c = 0; c < 10; c++) begin
      wr(3'h1, 2'h2, 1'b0, 1'b0, 32'h123456f0);
      wr(3'h2, 2'h2, 1'b0, 1'b0, 32'h00010120);
      i_cgrf_exec_model.issue(4'(c), 2'(c % 3), lat);
      chk(32'(lat), (c < 6) ? 32'd2 : (c < 8) ? 32'd14 : 32'd22, "latency");
      rd(3'h1, 2'h2, 1'b0, 1'b0, v);
      chk(v, ex[c], "op result");
    end
    $display("t_ops done");
  endtask
  task automatic t_pc;
    @(posedge sys_clk);
    pc_cmd <= cgrf_pkg::CGRF_PC_STEP;
    repeat (3) @(posedge sys_clk);
    {pc_cmd, pc_load_value} <= {cgrf_pkg::CGRF_PC_LOAD, 24'habcdef};
    @(negedge sys_clk);
    chk(32'(program_counter), 32'h0000123b, "pc step");
    chk(32'(fetch_addr), 32'h0000123a, "odd pc fetch");
    @(posedge sys_clk);
    pc_cmd <= cgrf_pkg::CGRF_PC_HOLD;
    @(negedge sys_clk);
    chk(32'(fetch_addr), 32'h0000cdee, "loaded pc fetch");
    $display("t_pc done");
  endtask
  task automatic t_sp;
    wr(3'h7, 2'h2, 1'b0, 1'b0, 32'hff001000);
    sp_cmd <= cgrf_pkg::CGRF_SP_PUSH_WORD;
    @(posedge sys_clk);
    sp_cmd <= cgrf_pkg::CGRF_SP_PUSH_LONG;
    @(posedge sys_clk);
    sp_cmd <= cgrf_pkg::CGRF_SP_POP_LONG;
    @(posedge sys_clk);
    sp_cmd <= cgrf_pkg::CGRF_SP_HOLD;
    @(negedge sys_clk);
    chk(32'(stack_pointer), 32'h00000ffe, "stack pointer");
    rd(3'h7, 2'h2, 1'b0, 1'b0, v);
    chk(v, 32'h00000ffe, "register seven");
    $display("t_sp done");
  endtask
  task automatic t_ccr;
    @(posedge sys_clk);
    {ccr_wr_en, ccr_wr_data} <= {1'b1, 8'h2a};
    @(posedge sys_clk);
    ccr_wr_en <= 1'b0;
    @(negedge sys_clk);
    chk(32'(condition_code_reg), 32'h0000002a, "ccr write");
    @(posedge sys_clk);
    {ccr_wr_en, ccr_wr_data, ccr_imask_set} <= {1'b1, 8'h05, 1'b1};
    @(posedge sys_clk);
    {ccr_wr_en, ccr_imask_set} <= 2'h0;
    @(negedge sys_clk);
    chk(32'(condition_code_reg), 32'h00000085, "mask wins");
    $display("t_ccr done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence, and a watchdog far beyond its length
  initial begin
    t_reset;
    t_gen;
    t_ops;
    t_pc;
    t_sp;
    t_ccr;
    close_out;
  end
  initial begin
    #100us;
    n_mismatch++;
    close_out;
  end
endmodule // cgrf_top_tb
`default_nettype wire

// ===== rtl/cgrf_alu.sv
// arithmetic unit: add and subtract at three widths, multiply and divide
`timescale 1ns/100ps
`default_nettype none
module cgrf_alu (
  input wire logic [3:0] op,
  input wire logic [31:0] dst_value,
  input wire logic [31:0] src_value,
  output logic [31:0] result
);
  logic [15:0] divisor16;
  logic [7:0] divisor8;
  // divide by zero returns the dividend unchanged as the result, cut to its low 16 bits for the 16 by 8 divide
  always_comb begin
    divisor16 = src_value[15:0];
    divisor8 = src_value[7:0];
    result = dst_value;
    unique case (op)
      4'(cgrf_pkg::CGRF_OP_ADD8): result = {24'h000000, 8'(dst_value[7:0] + src_value[7:0])};
      4'(cgrf_pkg::CGRF_OP_ADD16): result = {16'h0000, 16'(dst_value[15:0] + src_value[15:0])};
      4'(cgrf_pkg::CGRF_OP_ADD32): result = 32'(dst_value + src_value);
      4'(cgrf_pkg::CGRF_OP_SUB8): result = {24'h000000, 8'(dst_value[7:0] - src_value[7:0])};
      4'(cgrf_pkg::CGRF_OP_SUB16): result = {16'h0000, 16'(dst_value[15:0] - src_value[15:0])};
      4'(cgrf_pkg::CGRF_OP_SUB32): result = 32'(dst_value - src_value);
      4'(cgrf_pkg::CGRF_OP_MUL8): result = {16'h0000, 16'(dst_value[7:0] * src_value[7:0])};
      4'(cgrf_pkg::CGRF_OP_MUL16): result = 32'(dst_value[15:0] * src_value[15:0]);
      4'(cgrf_pkg::CGRF_OP_DIV16): begin
        if (divisor8 == 8'h00) result = {16'h0000, dst_value[15:0]};
        else result = {16'h0000, 8'(dst_value[15:0] % divisor8), 8'(dst_value[15:0] / divisor8)};
      end
      4'(cgrf_pkg::CGRF_OP_DIV32): begin
        if (divisor16 == 16'h0000) result = dst_value;
        else result = {16'(dst_value % divisor16), 16'(dst_value / divisor16)};
      end
      default: result = dst_value;
    endcase
  end
endmodule // cgrf_alu
`default_nettype wire

// ===== rtl/cgrf_lane.sv
// one lane slice: selects and places a byte, half or word of a general register
`timescale 1ns/100ps
`default_nettype none
module cgrf_lane (
  input wire logic [31:0] full_value,
  input wire logic [1:0] width,
  input wire logic ext_half,
  input wire logic high_byte,
  input wire logic [31:0] write_data,
  output logic [31:0] read_value,
  output logic [31:0] merged_value
);
  // read extracts the lane right-aligned; write merges only the chosen lane
  always_comb begin
    read_value = full_value;
    merged_value = full_value;
    unique case (width)
      2'(cgrf_pkg::CGRF_W_WORD): begin
        read_value = full_value;
        merged_value = write_data;
      end
      2'(cgrf_pkg::CGRF_W_HALF): begin
        if (ext_half) begin
          read_value = {16'h0000, full_value[31:16]};
          merged_value = {write_data[15:0], full_value[15:0]};
        end else begin
          read_value = {16'h0000, full_value[15:0]};
          merged_value = {full_value[31:16], write_data[15:0]};
        end
      end
      2'(cgrf_pkg::CGRF_W_BYTE): begin
        if (high_byte) begin
          read_value = {24'h000000, full_value[15:8]};
          merged_value = {full_value[31:16], write_data[7:0], full_value[7:0]};
        end else begin
          read_value = {24'h000000, full_value[7:0]};
          merged_value = {full_value[31:8], write_data[7:0]};
        end
      end
      default: begin
        read_value = full_value;
        merged_value = full_value;
      end
    endcase
  end
endmodule // cgrf_lane
`default_nettype wire

// ===== rtl/cgrf_pkg.sv
// package: widths, encodings, reset values and cycle counts for the cpu register file
package cgrf_pkg;
  localparam int unsigned GEN_REGS = 8;
  localparam int unsigned GEN_WIDTH = 32;
  localparam int unsigned PC_WIDTH = 24;
  localparam int unsigned CCR_WIDTH = 8;
  localparam int unsigned ADDR_WIDTH = 16;
  localparam logic [2:0] SP_INDEX = 3'h7;
  localparam int unsigned CCR_IMASK_BIT = 7;
  localparam logic [31:0] GEN_RESET = 32'h00000000;
  localparam logic [23:0] PC_RESET = 24'h000000;
  localparam logic [7:0] CCR_RESET = 8'h80;
  localparam logic [23:0] STACK_STEP = 24'h000002;
  localparam logic [23:0] LONG_STEP = 24'h000004;
  // operation latencies in cpu states, one state per sys_clk cycle
  localparam int unsigned ADDSUB_STATES = 2;
  localparam int unsigned SHORT_MULDIV_STATES = 14;
  localparam int unsigned LONG_MULDIV_STATES = 22;
  localparam logic [4:0] ADDSUB_COUNT = 5'(ADDSUB_STATES - 1);
  localparam logic [4:0] SHORT_MULDIV_COUNT = 5'(SHORT_MULDIV_STATES - 1);
  localparam logic [4:0] LONG_MULDIV_COUNT = 5'(LONG_MULDIV_STATES - 1);

  // access width of a general register port
  typedef enum logic [1:0] {
    CGRF_W_BYTE = 2'h0,
    CGRF_W_HALF = 2'h1,
    CGRF_W_WORD = 2'h2
  } cgrf_width_t;

  // arithmetic operation codes
  typedef enum logic [3:0] {
    CGRF_OP_ADD8 = 4'h0,
    CGRF_OP_ADD16 = 4'h1,
    CGRF_OP_ADD32 = 4'h2,
    CGRF_OP_SUB8 = 4'h3,
    CGRF_OP_SUB16 = 4'h4,
    CGRF_OP_SUB32 = 4'h5,
    CGRF_OP_MUL8 = 4'h6,
    CGRF_OP_DIV16 = 4'h7,
    CGRF_OP_MUL16 = 4'h8,
    CGRF_OP_DIV32 = 4'h9
  } cgrf_op_t;

  // program counter update commands
  typedef enum logic [1:0] {
    CGRF_PC_HOLD = 2'h0,
    CGRF_PC_STEP = 2'h1,
    CGRF_PC_LOAD = 2'h2,
    CGRF_PC_VECTOR = 2'h3
  } cgrf_pc_cmd_t;

  // stack pointer adjust commands
  typedef enum logic [1:0] {
    CGRF_SP_HOLD = 2'h0,
    CGRF_SP_PUSH_WORD = 2'h1,
    CGRF_SP_PUSH_LONG = 2'h2,
    CGRF_SP_POP_LONG = 2'h3
  } cgrf_sp_cmd_t;
endpackage

// ===== rtl/cgrf_top.sv
// cpu general register file with program counter, condition codes and timed arithmetic
// How it works
// - eight general registers of 32 bits each are held here.
// - every general register has the same lane logic and may feed addresses or data.
// - data access to a general register is by word, half or byte.
// - each register splits into an extended upper half and a basic lower half.
// - each basic half splits into a high byte and a low byte.
// - the width and role of each access is chosen per register, independently.
// - register seven is also the stack pointer used by calls, returns and exceptions.
// - a 24-bit program counter holds the address of the next instruction.
// - the program counter's lowest bit is treated as zero on every fetch.
// - the reset sequence loads the program counter from the reset vector.
// - an 8-bit condition code register sits beside the general registers.
// - only the normal mode with one 64-kbyte space is supported.
// - register add and subtract at 8, 16 or 32 bits take 2 states.
// - 8 by 8 multiply and 16 by 8 divide take 14 states.
// - 16 by 16 multiply and 32 by 16 divide take 22 states.
// - reset sets the interrupt mask bit of the condition codes to one.
`timescale 1ns/100ps
`default_nettype none
module cgrf_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [2:0] rd_a_index,
  input wire logic [1:0] rd_a_width,
  input wire logic rd_a_ext,
  input wire logic rd_a_high,
  input wire logic [2:0] rd_b_index,
  input wire logic [1:0] rd_b_width,
  input wire logic rd_b_ext,
  input wire logic rd_b_high,
  input wire logic wr_en,
  input wire logic [2:0] wr_index,
  input wire logic [1:0] wr_width,
  input wire logic wr_ext,
  input wire logic wr_high,
  input wire logic [31:0] wr_data,
  input wire logic op_start,
  input wire logic [3:0] op_code,
  input wire logic [2:0] op_dst_index,
  input wire logic [2:0] op_src_index,
  input wire logic [1:0] op_dst_width,
  input wire logic op_dst_ext,
  input wire logic op_dst_high,
  input wire logic [1:0] sp_cmd,
  input wire logic [1:0] pc_cmd,
  input wire logic [23:0] pc_load_value,
  input wire logic [15:0] reset_vector_data,
  input wire logic ccr_wr_en,
  input wire logic [7:0] ccr_wr_data,
  input wire logic ccr_imask_set,
  output logic [31:0] rd_a_data,
  output logic [31:0] rd_b_data,
  output logic [15:0] rd_a_addr,
  output logic [23:0] stack_pointer,
  output logic [23:0] program_counter,
  output logic [15:0] fetch_addr,
  output logic [7:0] condition_code_reg,
  output logic reset_sequence,
  output logic op_busy,
  output logic op_done
);
  ////////////////////////////////////////////////////////////////////////////
  // general register storage and lane views
  logic [31:0] wide_general_regs [cgrf_pkg::GEN_REGS];
  logic [31:0] next_wide_general_regs [cgrf_pkg::GEN_REGS];
  logic [31:0] lane_rd_a [cgrf_pkg::GEN_REGS];
  logic [31:0] lane_rd_b [cgrf_pkg::GEN_REGS];
  logic [31:0] lane_wr [cgrf_pkg::GEN_REGS];
  logic [31:0] lane_op [cgrf_pkg::GEN_REGS];
  logic [31:0] lane_op_rd [cgrf_pkg::GEN_REGS];
  logic [15:0] extended_halfword_regs [cgrf_pkg::GEN_REGS];
  logic [15:0] basic_halfword_regs [cgrf_pkg::GEN_REGS];
  logic [7:0] high_byte_regs [cgrf_pkg::GEN_REGS];
  logic [7:0] low_byte_regs [cgrf_pkg::GEN_REGS];
  // operation sequencer state
  typedef enum logic [1:0] {CGRF_IDLE, CGRF_BUSY, CGRF_WRITE} cgrf_opstate_t;
  cgrf_opstate_t op_state, next_op_state;
  logic [4:0] op_count, next_op_count;
  logic [3:0] op_hold, next_op_hold;
  logic [2:0] op_dst, next_op_dst;
  logic [2:0] op_src, next_op_src;
  logic [1:0] op_width, next_op_width;
  logic op_ext, next_op_ext;
  logic op_high, next_op_high;
  logic [31:0] alu_result;
  // control registers and outputs
  logic [23:0] next_program_counter;
  logic [7:0] next_condition_code_reg;
  logic reset_seq, next_reset_seq;
  logic [31:0] next_rd_a_data, next_rd_b_data;
  logic next_op_done;
  logic [23:0] sp_now;

  ////////////////////////////////////////////////////////////////////////////
  // every register gets the same lane logic; only register seven also takes the sp_cmd stack adjusts
  genvar g;
  generate
    for (g = 0; g < cgrf_pkg::GEN_REGS; g++) begin : g_reg
      // named half and byte views of each register
      assign extended_halfword_regs[g] = wide_general_regs[g][31:16];
      assign basic_halfword_regs[g] = wide_general_regs[g][15:0];
      assign high_byte_regs[g] = wide_general_regs[g][15:8];
      assign low_byte_regs[g] = wide_general_regs[g][7:0];
      // each port carries its own width choice, so ports never constrain each other
      cgrf_lane u_rd_a (
        .full_value(wide_general_regs[g]),
        .width(rd_a_width),
        .ext_half(rd_a_ext),
        .high_byte(rd_a_high),
        .write_data(32'h00000000),
        .read_value(lane_rd_a[g]),
        .merged_value()
      );
      cgrf_lane u_rd_b (
        .full_value(wide_general_regs[g]),
        .width(rd_b_width),
        .ext_half(rd_b_ext),
        .high_byte(rd_b_high),
        .write_data(32'h00000000),
        .read_value(lane_rd_b[g]),
        .merged_value()
      );
      // partial writes merge into the old contents
      cgrf_lane u_wr (
        .full_value(wide_general_regs[g]),
        .width(wr_width),
        .ext_half(wr_ext),
        .high_byte(wr_high),
        .write_data(wr_data),
        .read_value(),
        .merged_value(lane_wr[g])
      );
      cgrf_lane u_op (
        .full_value(wide_general_regs[g]),
        .width(op_width),
        .ext_half(op_ext),
        .high_byte(op_high),
        .write_data(alu_result),
        .read_value(lane_op_rd[g]),
        .merged_value(lane_op[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // operation sequencer: latency counted from op_start to the write state
  cgrf_alu u_alu (
    .op(op_hold),
    .dst_value(lane_op_rd[op_dst]),
    .src_value(lane_op_rd[op_src]),
    .result(alu_result)
  );

  // the write lands in the last state, so op_done pulses exactly n cycles after op_start
  always_comb begin
    next_op_state = op_state;
    next_op_count = op_count;
    next_op_hold = op_hold;
    next_op_dst = op_dst;
    next_op_src = op_src;
    next_op_width = op_width;
    next_op_ext = op_ext;
    next_op_high = op_high;
    next_op_done = 1'b0;
    unique case (op_state)
      CGRF_IDLE: begin
        if (op_start && !reset_seq) begin
          next_op_hold = op_code;
          next_op_dst = op_dst_index;
          next_op_src = op_src_index;
          next_op_width = op_dst_width;
          next_op_ext = op_dst_ext;
          next_op_high = op_dst_high;
          if (op_code <= 4'(cgrf_pkg::CGRF_OP_SUB32)) begin
            next_op_count = cgrf_pkg::ADDSUB_COUNT - 5'h01;
          end else if (op_code <= 4'(cgrf_pkg::CGRF_OP_DIV16)) begin
            next_op_count = cgrf_pkg::SHORT_MULDIV_COUNT - 5'h01;
          end else begin
            next_op_count = cgrf_pkg::LONG_MULDIV_COUNT - 5'h01;
          end
          next_op_state = (next_op_count == 5'h00) ? CGRF_WRITE : CGRF_BUSY;
        end
      end
      CGRF_BUSY: begin
        next_op_count = op_count - 5'h01;
        if (op_count == 5'h01) next_op_state = CGRF_WRITE;
      end
      CGRF_WRITE: begin
        next_op_state = CGRF_IDLE;
        next_op_done = 1'b1;
      end
      default: next_op_state = CGRF_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      op_state <= CGRF_IDLE;
      op_count <= 5'h00;
      op_hold <= 4'h0;
      op_dst <= 3'h0;
      op_src <= 3'h0;
      op_width <= 2'h0;
      op_ext <= 1'b0;
      op_high <= 1'b0;
      op_done <= 1'b0;
    end else begin
      op_state <= next_op_state;
      op_count <= next_op_count;
      op_hold <= next_op_hold;
      op_dst <= next_op_dst;
      op_src <= next_op_src;
      op_width <= next_op_width;
      op_ext <= next_op_ext;
      op_high <= next_op_high;
      op_done <= next_op_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register write, stack pointer adjust; arithmetic result wins over a port write
  assign sp_now = wide_general_regs[cgrf_pkg::SP_INDEX][23:0];
  always_comb begin
    for (int i = 0; i < cgrf_pkg::GEN_REGS; i++) begin
      next_wide_general_regs[i] = wide_general_regs[i];
    end
    // implicit stack use by calls, returns and exception entry
    unique case (sp_cmd)
      2'(cgrf_pkg::CGRF_SP_PUSH_WORD):
        next_wide_general_regs[cgrf_pkg::SP_INDEX] =
          {8'h00, 24'(sp_now - cgrf_pkg::STACK_STEP)};
      2'(cgrf_pkg::CGRF_SP_PUSH_LONG):
        next_wide_general_regs[cgrf_pkg::SP_INDEX] =
          {8'h00, 24'(sp_now - cgrf_pkg::LONG_STEP)};
      2'(cgrf_pkg::CGRF_SP_POP_LONG):
        next_wide_general_regs[cgrf_pkg::SP_INDEX] =
          {8'h00, 24'(sp_now + cgrf_pkg::LONG_STEP)};
      default: ;
    endcase
    if (wr_en) next_wide_general_regs[wr_index] = lane_wr[wr_index];
    if (op_state == CGRF_WRITE) next_wide_general_regs[op_dst] = lane_op[op_dst];
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int i = 0; i < cgrf_pkg::GEN_REGS; i++) begin
        wide_general_regs[i] <= cgrf_pkg::GEN_RESET;
      end
    end else begin
      for (int i = 0; i < cgrf_pkg::GEN_REGS; i++) begin
        wide_general_regs[i] <= next_wide_general_regs[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // program counter, reset sequence and condition codes
  always_comb begin
    next_program_counter = program_counter;
    next_reset_seq = reset_seq;
    next_condition_code_reg = condition_code_reg;
    if (reset_seq) begin
      // one cycle after reset the vector word is taken as the start address
      next_program_counter = {8'h00, reset_vector_data};
      next_reset_seq = 1'b0;
    end else begin
      unique case (pc_cmd)
        2'(cgrf_pkg::CGRF_PC_STEP):
          next_program_counter = 24'(program_counter + cgrf_pkg::STACK_STEP);
        2'(cgrf_pkg::CGRF_PC_LOAD): next_program_counter = pc_load_value;
        2'(cgrf_pkg::CGRF_PC_VECTOR):
          next_program_counter = {8'h00, reset_vector_data};
        default: ;
      endcase
    end
    if (ccr_wr_en) next_condition_code_reg = ccr_wr_data;
    // exception entry masks interrupts, and wins over a same-cycle write
    if (ccr_imask_set) next_condition_code_reg[cgrf_pkg::CCR_IMASK_BIT] = 1'b1;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      program_counter <= cgrf_pkg::PC_RESET;
      reset_seq <= 1'b1;
      // only the mask bit has a defined reset value; the rest read as zero here
      condition_code_reg <= cgrf_pkg::CCR_RESET;
    end else begin
      program_counter <= next_program_counter;
      reset_seq <= next_reset_seq;
      condition_code_reg <= next_condition_code_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered read ports and derived addresses
  always_comb begin
    next_rd_a_data = lane_rd_a[rd_a_index];
    next_rd_b_data = lane_rd_b[rd_b_index];
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_a_data <= 32'h00000000;
      rd_b_data <= 32'h00000000;
      rd_a_addr <= 16'h0000;
      stack_pointer <= 24'h000000;
      fetch_addr <= 16'h0000;
      reset_sequence <= 1'b0;
      op_busy <= 1'b0;
    end else begin
      rd_a_data <= next_rd_a_data;
      rd_b_data <= next_rd_b_data;
      // any register may serve as an address; normal mode keeps 16 bits
      rd_a_addr <= wide_general_regs[rd_a_index][15:0];
      stack_pointer <= next_wide_general_regs[cgrf_pkg::SP_INDEX][23:0];
      // fetch address drops the lowest bit of the counter
      fetch_addr <= {next_program_counter[15:1], 1'b0};
      reset_sequence <= reset_seq;
      op_busy <= (next_op_state != CGRF_IDLE);
    end
  end
endmodule // cgrf_top
`default_nettype wire
